// file: pbs_defines.vh
// Constants for the basic port status register of the PHY management block.
// Assumes the management frame engine presents register index, data and strobes.
//
// What this block does
// - 16-bit status register at management index 1.
// - Reset loads every bit with default.
// - Bit 15 reads zero, never writable.
// - Capability bits 14..11 reset to one.
// - Capability bits 14..11 are override-writable.
// - Override writes only while override enable set.
// - Reserved bits 10..7 reset zero, override-writable.
// - Reserved bits always read as zero.
// - Bit 6 preamble suppression, resets to zero.
// - Bit 5 negotiation complete, latch high.
// - Bit 4 remote fault, latch high.
// - Bits 0 and 3 always read one.
// - Bit 2 link status, latch low.
// - Bit 1 jabber, latch high, read clears.
// - Remote fault latch cleared by read.
// - Negotiation complete zero while negotiation disabled.
`ifndef PBS_DEFINES_VH
`define PBS_DEFINES_VH

// ==========================================================
// Register map
`define PBS_REG_INDEX 5'h01
`define PBS_RESET_VALUE 16'h7809

// ==========================================================
// Field positions
`define PBS_BIT_T4 15
`define PBS_CAP_HI 14
`define PBS_CAP_LO 11
`define PBS_RSV_HI 10
`define PBS_RSV_LO 7
`define PBS_BIT_PRE 6
`define PBS_BIT_ANC 5
`define PBS_BIT_RF 4
`define PBS_BIT_ANA 3
`define PBS_BIT_LINK 2
`define PBS_BIT_JAB 1
`define PBS_BIT_EXT 0

// ==========================================================
// Reset values of the writable fields
`define PBS_CAP_RESET 4'hf
`define PBS_RSV_RESET 4'h0
`define PBS_PRE_RESET 1'h0

`endif

// file: pbs_latch_high.v
// One latching-high status bit.
// Assumes the read strobe is a one-cycle pulse in the clock domain.
`timescale 1ns/10ps
`default_nettype none
module pbs_latch_high (
    // Clock and reset
    input wire i_clock,
    input wire i_arst_n,
    // Condition and clearing
    input wire i_cond,
    input wire i_read,
    input wire i_flush,
    // Latched value
    output reg o_value
);
// ==========================================================
// Latch
// The event wins over a read in the same cycle, so it is never lost.
always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
        o_value <= 1'b0;
    end else if (i_cond) begin
        o_value <= 1'b1;
    end else if (i_read || i_flush) begin
        o_value <= 1'b0;
    end
end
endmodule
`default_nettype wire

// file: pbs_latch_low.v
// One latching-low status bit.
// Assumes the read strobe is a one-cycle pulse in the clock domain.
`timescale 1ns/10ps
`default_nettype none
module pbs_latch_low (
    // Clock and reset
    input wire i_clock,
    input wire i_arst_n,
    // Condition and clearing
    input wire i_cond,
    input wire i_read,
    input wire i_flush,
    // Latched value
    output reg o_value
);
// ==========================================================
// Latch
// A drop wins over a read in the same cycle; a read re-arms to the current level.
always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
        o_value <= 1'b0;
    end else if (!i_cond || i_flush) begin
        o_value <= 1'b0;
    end else if (i_read) begin
        o_value <= 1'b1;
    end
end
endmodule
`default_nettype wire

// file: pbs_basic_port_status.v
// Basic port status register reached by the management frame engine.
// Assumes register index, write data and one-cycle read and write strobes come from that engine.
`timescale 1ns/10ps
`default_nettype none
`include "pbs_defines.vh"
module pbs_basic_port_status (
    // Clock and reset
    input wire i_clock,
    input wire i_arst_n,
    // Management access
    input wire [4:0] i_reg_index,
    input wire i_read,
    input wire i_write,
    input wire [15:0] i_write_data,
    output reg [15:0] o_read_data,
    output wire o_selected,
    // Controls from other registers
    input wire i_override_writable,
    input wire i_autoneg_enable,
    input wire i_low_power_entry,
    // Live conditions
    input wire i_autoneg_done,
    input wire i_remote_fault,
    input wire i_link_valid,
    input wire i_jabber,
    // Stored capability outputs
    output wire [3:0] o_capability,
    output wire o_preamble_suppress
);
// ==========================================================
// Helper functions
// The index compare is shared by the read and the write path.
function pbs_hit(input [4:0] index);
    begin
        pbs_hit = (index == `PBS_REG_INDEX);
    end
endfunction

// Field extraction from a management write word.
function [3:0] pbs_cap_field(input [15:0] word);
    begin
        pbs_cap_field = word[`PBS_CAP_HI:`PBS_CAP_LO];
    end
endfunction

function [3:0] pbs_rsv_field(input [15:0] word);
    begin
        pbs_rsv_field = word[`PBS_RSV_HI:`PBS_RSV_LO];
    end
endfunction

function pbs_pre_field(input [15:0] word);
    begin
        pbs_pre_field = word[`PBS_BIT_PRE];
    end
endfunction

// Builds the word returned to the controller from the stored and latched bits.
// Fixed bits are forced here so no stored value can ever leak into them.
function [15:0] pbs_compose(
    input [3:0] cap,
    input pre,
    input anc,
    input rf,
    input link,
    input jab
);
    begin
        pbs_compose = 16'h0000;
        pbs_compose[`PBS_BIT_T4] = 1'b0;
        pbs_compose[`PBS_CAP_HI:`PBS_CAP_LO] = cap;
        pbs_compose[`PBS_RSV_HI:`PBS_RSV_LO] = 4'h0;
        pbs_compose[`PBS_BIT_PRE] = pre;
        pbs_compose[`PBS_BIT_ANC] = anc;
        pbs_compose[`PBS_BIT_RF] = rf;
        pbs_compose[`PBS_BIT_ANA] = 1'b1;
        pbs_compose[`PBS_BIT_LINK] = link;
        pbs_compose[`PBS_BIT_JAB] = jab;
        pbs_compose[`PBS_BIT_EXT] = 1'b1;
    end
endfunction

// ==========================================================
// Decode
reg [3:0] capability;
reg [3:0] reserved_store;
reg preamble_suppress;
reg [3:0] next_capability;
reg [3:0] next_reserved_store;
reg next_preamble_suppress;
reg [15:0] next_read_data;
wire anc_cond;
wire anc_flush;
wire sel;
wire rd;
wire wr;
wire anc_bit;
wire rf_bit;
wire link_bit;
wire jab_bit;
wire [15:0] view;

assign sel = pbs_hit(i_reg_index);
assign anc_cond = i_autoneg_enable && i_autoneg_done;
assign anc_flush = i_low_power_entry || !i_autoneg_enable;
assign rd = sel && i_read;
assign wr = sel && i_write;
assign o_selected = sel;
assign o_capability = capability;
assign o_preamble_suppress = preamble_suppress;

// ==========================================================
// Override-writable fields
// The reserved store is kept but never shown; the controller should write zeros there anyway.
always @* begin
    next_capability = capability;
    next_reserved_store = reserved_store;
    next_preamble_suppress = preamble_suppress;
    if (wr && i_override_writable) begin
        next_capability = pbs_cap_field(i_write_data);
        next_reserved_store = pbs_rsv_field(i_write_data);
        next_preamble_suppress = pbs_pre_field(i_write_data);
    end
end

always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
        capability <= `PBS_CAP_RESET;
        reserved_store <= `PBS_RSV_RESET;
        preamble_suppress <= `PBS_PRE_RESET;
    end else begin
        capability <= next_capability;
        reserved_store <= next_reserved_store;
        preamble_suppress <= next_preamble_suppress;
    end
end

// ==========================================================
// Latched status bits
pbs_latch_high u_anc (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_cond(anc_cond),
    .i_read(rd),
    .i_flush(anc_flush),
    .o_value(anc_bit)
);
pbs_latch_high u_rf (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_cond(i_remote_fault),
    .i_read(rd),
    .i_flush(i_low_power_entry),
    .o_value(rf_bit)
);
pbs_latch_high u_jab (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_cond(i_jabber),
    .i_read(rd),
    .i_flush(i_low_power_entry),
    .o_value(jab_bit)
);
pbs_latch_low u_link (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_cond(i_link_valid),
    .i_read(rd),
    .i_flush(i_low_power_entry),
    .o_value(link_bit)
);

// ==========================================================
// Read view
assign view = pbs_compose(capability, preamble_suppress, anc_bit & i_autoneg_enable,
                          rf_bit, link_bit, jab_bit);

always @* begin
    next_read_data = o_read_data;
    if (rd) begin
        next_read_data = view;
    end
end

// Read data is captured on the read strobe so the returned word is the one before the read clears it.
always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
        o_read_data <= 16'h0000;
    end else begin
        o_read_data <= next_read_data;
    end
end
endmodule
`default_nettype wire

// file: pbs_basic_port_status_assertions.sv
// Checker for the basic port status register.
// Assumes only the top module's ports are visible.
`timescale 1ns/10ps
`default_nettype none
module pbs_basic_port_status_assertions (
    input wire logic i_clock, i_arst_n, i_read, i_write, i_override_writable, i_autoneg_enable,
    input wire logic i_low_power_entry, i_remote_fault, i_link_valid, i_jabber, o_selected, o_preamble_suppress,
    input wire logic [4:0] i_reg_index,
    input wire logic [15:0] i_write_data, o_read_data,
    input wire logic [3:0] o_capability
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);
    sequence s_rd;
        o_selected && i_read;
    endsequence
    // An event followed by one quiet edge, then a read.
    sequence s_late(logic ev);
        ev ##1 (!(o_selected && i_read) && !i_low_power_entry) ##1 s_rd;
    endsequence
    property p_idx; o_selected == (i_reg_index == 5'h01); endproperty
    a_idx: assert property (p_idx) else $error("select wrong");
    property p_fix; s_rd |=> o_read_data[15] == 0 && o_read_data[10:7] == 0 && o_read_data[3] && o_read_data[0];
    endproperty
    a_fix: assert property (p_fix) else $error("fixed bits wrong");
    property p_cap; s_rd |=> o_read_data[14:11] == $past(o_capability) && o_read_data[6] == $past(o_preamble_suppress);
    endproperty
    a_cap: assert property (p_cap) else $error("stored bits misread");
    property p_wr; o_selected && i_write && i_override_writable |=> o_capability == $past(i_write_data[14:11]);
    endproperty
    a_wr: assert property (p_wr) else $error("override write lost");
    property p_keep; o_selected && i_write && !i_override_writable |=> $stable(o_capability); endproperty
    a_keep: assert property (p_keep) else $error("locked write took effect");
    property p_anc; o_selected && i_read && !i_autoneg_enable |=> !o_read_data[5]; endproperty
    a_anc: assert property (p_anc) else $error("complete shown while disabled");
    property p_rf; s_late(i_remote_fault) |=> o_read_data[4]; endproperty
    a_rf: assert property (p_rf) else $error("fault not held");
    property p_jab; s_late(i_jabber) |=> o_read_data[1]; endproperty
    a_jab: assert property (p_jab) else $error("jabber not held");
    // A drop seen one edge before the read must already be held in the returned word.
    property p_link; !i_link_valid ##1 s_rd |=> !o_read_data[2]; endproperty
    a_link: assert property (p_link) else $error("link shown while down");
    property p_flush; i_low_power_entry && !i_remote_fault && !i_jabber ##1 s_rd |=>
        !o_read_data[4] && !o_read_data[2] && !o_read_data[1];
    endproperty
    a_flush: assert property (p_flush) else $error("latches not flushed");
endmodule
bind pbs_basic_port_status pbs_basic_port_status_assertions pbs_chk_i (.*);
`default_nettype wire

// file: pbs_sta_model.sv
// Management controller model issuing register accesses.
// Assumes calls start just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module pbs_sta_model (
    input wire logic i_clock,
    output logic [4:0] o_reg_index,
    output logic o_read,
    output logic o_write,
    output logic [15:0] o_write_data
);
    initial begin
        o_reg_index = 5'h01;
        o_read = 0;
        o_write = 0;
        o_write_data = 16'h0000;
    end
    // Idle lines wander so a stale value is never mistaken for a request.
    task automatic access(input logic w, input logic [15:0] d);
        o_reg_index <= 5'h01;
        o_read <= !w;
        o_write <= w;
        o_write_data <= d & 16'hf87f;
        @(posedge i_clock);
        o_read <= 0;
        o_write <= 0;
        o_write_data <= ~d;
        o_reg_index <= 5'($urandom);
        @(posedge i_clock);
    endtask
endmodule
`default_nettype wire

// file: pbs_basic_port_status_bench.sv
// Self-checking bench for the basic port status register.
// Assumes the controller model and the checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module pbs_basic_port_status_bench;
    logic clk = 0, rst_n = 0, ov = 0, an = 0, dn = 0, rf = 0, lv = 0, jb = 0, rd, wr, sel, pre, rd_d = 0, lp = 0;
    logic [4:0] idx;
    logic [15:0] wd, rdata, d;
    logic [15:0] exp_q[$];
    logic [3:0] cap;
    int fails = 0, comparisons = 0;
    always #2 clk = ~clk;
    pbs_sta_model pbs_sta_model_i (.i_clock(clk), .o_reg_index(idx), .o_read(rd), .o_write(wr), .o_write_data(wd));
    pbs_basic_port_status pbs_basic_port_status_i (.i_clock(clk), .i_arst_n(rst_n), .i_reg_index(idx),
        .i_read(rd), .i_write(wr), .i_write_data(wd), .o_read_data(rdata), .o_selected(sel),
        .i_override_writable(ov), .i_autoneg_enable(an), .i_low_power_entry(lp), .i_autoneg_done(dn),
        .i_remote_fault(rf), .i_link_valid(lv), .i_jabber(jb), .o_capability(cap), .o_preamble_suppress(pre));
    task automatic rd_exp(input logic [15:0] e);
        exp_q.push_back(e);
        pbs_sta_model_i.access(1'b0, 16'h0000);
    endtask
    task automatic complete_run();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic compare_read(input logic [15:0] e, input logic [15:0] s);
        comparisons++;
        if (e !== s) begin
            fails++;
            $display("mismatch read_data expected %h seen %h", e, s);
        end
    endtask
    always @(posedge clk) begin
        if (rd_d) compare_read(exp_q.pop_front(), rdata);
        rd_d <= rd && sel;
    end
    initial begin
        #4000;
        fails++;
        complete_run();
    end
    initial begin
        void'($urandom(69));
        repeat (20) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        rd_exp(16'h7809);
        $display("test reset defaults done");
        an <= 1;
        lv <= 1;
        {dn, rf, jb} <= 3'h7;
        @(posedge clk);
        {dn, rf, jb} <= 3'h0;
        rd_exp(16'h783b);
        rd_exp(16'h780d);
        lv <= 0;
        @(posedge clk);
        lv <= 1;
        rd_exp(16'h7809);
        an <= 0;
        dn <= 1;
        rd_exp(16'h780d);
        $display("test latched bits done");
        pbs_sta_model_i.access(1'b1, 16'($urandom));
        rd_exp(16'h780d);
        ov <= 1;
        repeat (4) begin
            d = 16'($urandom);
            pbs_sta_model_i.access(1'b1, d);
            rd_exp({1'b0, d[14:11], 4'h0, d[6], 6'h0d});
        end
        $display("test override writes done");
        rf <= 1;
        @(posedge clk);
        rf <= 0;
        lp <= 1;
        @(posedge clk);
        lp <= 0;
        rd_exp({1'b0, d[14:11], 4'h0, d[6], 6'h09});
        $display("test low power flush done");
        rst_n <= 0;
        @(posedge clk);
        rst_n <= 1;
        rd_exp(16'h7809);
        $display("test second reset done");
        @(posedge clk);
        complete_run();
    end
endmodule
`default_nettype wire
